// [hw/csw_regs.svh]
// constants for the cpu clock select and oscillator watchdog block
// assumes inclusion by bare name from the package and the main module
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH

// clock-mode strap codes
`define CSW_STRAP_X4       3'h7
`define CSW_STRAP_X3       3'h6
`define CSW_STRAP_X8       3'h5
`define CSW_STRAP_X5       3'h4
`define CSW_STRAP_DIRECT   3'h3
`define CSW_STRAP_X10      3'h2
`define CSW_STRAP_PRESCALE 3'h1
`define CSW_STRAP_X16      3'h0

// divider chain per strap: {input div, vco multiply, output div, bypass, out prescale}
`define CSW_CFG_X4       {3'h4, 7'h40, 3'h4, 1'b0, 1'b0}
`define CSW_CFG_X3       {3'h4, 7'h30, 3'h4, 1'b0, 1'b0}
`define CSW_CFG_X8       {3'h4, 7'h40, 3'h2, 1'b0, 1'b0}
`define CSW_CFG_X5       {3'h4, 7'h28, 3'h2, 1'b0, 1'b0}
`define CSW_CFG_X10      {3'h2, 7'h28, 3'h2, 1'b0, 1'b0}
`define CSW_CFG_X16      {3'h2, 7'h40, 3'h2, 1'b0, 1'b0}
`define CSW_CFG_DIRECT   {3'h0, 7'h00, 3'h0, 1'b1, 1'b0}
`define CSW_CFG_PRESCALE {3'h0, 7'h00, 3'h0, 1'b1, 1'b1}

// multiplication factors, used as input-transition count between resyncs
`define CSW_F_X4  5'h04
`define CSW_F_X3  5'h03
`define CSW_F_X8  5'h08
`define CSW_F_X5  5'h05
`define CSW_F_X10 5'h0a
`define CSW_F_X16 5'h10

// watchdog overflow: pll clocks without an input transition
`define CSW_OWD_OVF_CYCLES 16
`define CSW_OWD_CNT_MAX    4'hf
// bidirectional reset drive length, in clk cycles (a cpu half period each only outside ext mode)
`define CSW_BIDIR_RST_TCL  11'h400
`define CSW_SYSCFG_WD_DIS_BIT 4

`endif

// [hw/csw_pkg.sv]
// types for the cpu clock select and oscillator watchdog block
// assumes csw_regs.svh is on the include path
package csw_pkg;
  `include "csw_regs.svh"

  // cpu clock source as seen by the clock mux
  typedef enum logic [1:0] {
    CSW_SRC_DIRECT   = 2'h0,
    CSW_SRC_PRESCALE = 2'h1,
    CSW_SRC_PLL_MULT = 2'h2,
    CSW_SRC_PLL_FREE = 2'h3
  } csw_src_t;

  // gray coded along init -> ext -> fail, init -> pll
  typedef enum logic [1:0] {
    CSW_ST_INIT = 2'h0,
    CSW_ST_EXT  = 2'h1,
    CSW_ST_FAIL = 2'h3,
    CSW_ST_PLL  = 2'h2
  } csw_state_t;

  typedef struct packed {
    logic [2:0] in_div;
    logic [6:0] vco_mul;
    logic [2:0] out_div;
    logic       bypass;
    logic       out_prescale;
  } csw_pll_cfg_t;
endpackage

// [hw/csw_sync.sv]
// two-stage synchroniser for a vector of independent levels
// assumes each bit is a slow level; no bus coherency across bits
`timescale 1ns/10ps
module csw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] hold_reg;

  // no reset: straps must be valid the moment reset lifts
  always_ff @(posedge clk) begin
    meta_reg <= d;
    hold_reg <= meta_reg;
  end

  assign q = hold_reg;
endmodule

// [hw/csw_clock_select.sv]
// cpu clock source selection, pll divider setup and oscillator watchdog
// assumes clk is the free-running pll clock; the analog mux and pll sit outside
`timescale 1ns/10ps
`include "csw_regs.svh"

module csw_clock_select (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  crystal_input_pin,
  input  wire logic [2:0]            clock_mode_straps,
  input  wire logic                  osc_watchdog_disable,
  input  wire logic                  pll_lock,
  input  wire logic                  bidir_reset_req,
  input  wire logic                  reset_input_pin_i,
  output logic                       reset_input_pin_o,
  output logic                       reset_input_pin_oe,
  output csw_pkg::csw_src_t          cpu_src,
  output csw_pkg::csw_pll_cfg_t      pll_cfg,
  output logic                       pll_enable,
  output logic                       osc_amp_bypass,
  output logic                       ref_disconnect,
  output logic                       cpu_phase,
  output logic                       pll_resync,
  output logic                       osc_wd_irq,
  output logic                       pll_unlock_irq,
  output logic                       reset_pin_low
);
  logic [1:0]            rst_sync_reg;
  logic                  rst_n;
  logic [5:0]            sync_q;
  logic                  xtal_s;
  logic [2:0]            straps_s;
  logic                  lock_s;
  logic                  rpin_s;
  logic                  xtal_edge;

  csw_pkg::csw_state_t   state_reg,   state_next;
  logic [2:0]            strap_reg,   strap_next;
  logic                  xtal_prev_reg, xtal_prev_next;
  logic [3:0]            wd_cnt_reg,  wd_cnt_next;
  logic [4:0]            tr_cnt_reg,  tr_cnt_next;
  logic [4:0]            factor;
  logic                  locked_reg,  locked_next;
  logic                  disc_reg,    disc_next;
  logic [10:0]           rst_cnt_reg, rst_cnt_next;
  csw_pkg::csw_src_t     src_reg,     src_next;
  csw_pkg::csw_pll_cfg_t cfg_reg,     cfg_next;
  logic                  pll_en_reg,  pll_en_next;
  logic                  phase_reg,   phase_next;
  logic                  resync_reg,  resync_next;
  logic                  wd_irq_reg,  wd_irq_next;
  logic                  ul_irq_reg,  ul_irq_next;
  logic                  drive_reg,   drive_next;
  logic                  rlow_reg,    rlow_next;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // every pin is foreign to clk, including the crystal input itself
  csw_sync #(.W(6)) u_sync (
    .clk (clk),
    .d   ({crystal_input_pin, clock_mode_straps, pll_lock, reset_input_pin_i}),
    .q   (sync_q)
  );
  assign xtal_s   = sync_q[5];
  assign straps_s = sync_q[4:2];
  assign lock_s   = sync_q[1];
  assign rpin_s   = sync_q[0];
  // masked in init: the edge flop still holds its reset level there, not the pin's
  assign xtal_edge = (xtal_s ^ xtal_prev_reg) & (state_reg != csw_pkg::CSW_ST_INIT);

  // divider chain and resync factor per strap code
  function automatic csw_pkg::csw_pll_cfg_t cfg_of(input logic [2:0] s);
    unique case (s)
      `CSW_STRAP_X4:       cfg_of = `CSW_CFG_X4;
      `CSW_STRAP_X3:       cfg_of = `CSW_CFG_X3;
      `CSW_STRAP_X8:       cfg_of = `CSW_CFG_X8;
      `CSW_STRAP_X5:       cfg_of = `CSW_CFG_X5;
      `CSW_STRAP_DIRECT:   cfg_of = `CSW_CFG_DIRECT;
      `CSW_STRAP_X10:      cfg_of = `CSW_CFG_X10;
      `CSW_STRAP_PRESCALE: cfg_of = `CSW_CFG_PRESCALE;
      `CSW_STRAP_X16:      cfg_of = `CSW_CFG_X16;
    endcase
  endfunction

  always_comb begin
    unique case (strap_reg)
      `CSW_STRAP_X4:  factor = `CSW_F_X4;
      `CSW_STRAP_X3:  factor = `CSW_F_X3;
      `CSW_STRAP_X8:  factor = `CSW_F_X8;
      `CSW_STRAP_X5:  factor = `CSW_F_X5;
      `CSW_STRAP_X10: factor = `CSW_F_X10;
      default:        factor = `CSW_F_X16; // ext codes never use it
    endcase
  end

  // next-state for mode, watchdog, pll supervision and reset driver
  always_comb begin
    state_next     = state_reg;
    strap_next     = strap_reg;
    xtal_prev_next = xtal_s;
    wd_cnt_next    = 4'h0;
    tr_cnt_next    = tr_cnt_reg;
    locked_next    = locked_reg;
    disc_next      = disc_reg;
    src_next       = src_reg;
    cfg_next       = cfg_reg;
    phase_next     = ~phase_reg;
    resync_next    = 1'b0;
    wd_irq_next    = 1'b0;
    ul_irq_next    = 1'b0;
    pll_en_next    = pll_en_reg;
    rlow_next      = ~rpin_s;
    unique case (state_reg)
      csw_pkg::CSW_ST_INIT: begin
        // straps latched once, on the first cycle after reset release
        strap_next = straps_s;
        cfg_next   = cfg_of(straps_s);
        if (straps_s == `CSW_STRAP_DIRECT || straps_s == `CSW_STRAP_PRESCALE) begin
          state_next = csw_pkg::CSW_ST_EXT;
        end else begin
          state_next  = csw_pkg::CSW_ST_PLL;
          src_next    = csw_pkg::CSW_SRC_PLL_MULT;
          pll_en_next = 1'b1;
        end
      end
      csw_pkg::CSW_ST_EXT: begin
        // external path is the source whenever no failure was seen
        src_next    = (strap_reg == `CSW_STRAP_DIRECT) ? csw_pkg::CSW_SRC_DIRECT
                                                       : csw_pkg::CSW_SRC_PRESCALE;
        pll_en_next = ~osc_watchdog_disable;
        if (strap_reg == `CSW_STRAP_DIRECT) begin
          phase_next = xtal_s;
        end else begin
          phase_next = phase_reg ^ (xtal_s & xtal_edge); // halves last one input period
        end
        if (!osc_watchdog_disable) begin
          if (xtal_edge) begin
            wd_cnt_next = 4'h0;
          end else if (wd_cnt_reg == `CSW_OWD_CNT_MAX) begin
            state_next  = csw_pkg::CSW_ST_FAIL;
            src_next    = csw_pkg::CSW_SRC_PLL_FREE;
            wd_irq_next = 1'b1;
            pll_en_next = 1'b1;
          end else begin
            wd_cnt_next = wd_cnt_reg + 4'h1;
          end
        end
      end
      csw_pkg::CSW_ST_FAIL: begin
        // no way back: a returning crystal is ignored until reset
        src_next    = csw_pkg::CSW_SRC_PLL_FREE;
        pll_en_next = 1'b1;
      end
      csw_pkg::CSW_ST_PLL: begin
        if (lock_s) begin
          locked_next = 1'b1;
        end
        if (locked_reg && !lock_s && !disc_reg) begin
          disc_next   = 1'b1;
          ul_irq_next = 1'b1;
          src_next    = csw_pkg::CSW_SRC_PLL_FREE;
        end
        // no resync once the reference is cut, not even in the cycle of the cut
        if (xtal_edge && !disc_next) begin
          if (tr_cnt_reg + 5'h01 == factor) begin
            tr_cnt_next = 5'h00;
            resync_next = 1'b1;
          end else begin
            tr_cnt_next = tr_cnt_reg + 5'h01;
          end
        end
      end
    endcase
    // pin is held low by counting down; a new request while busy is absorbed
    if (bidir_reset_req && rst_cnt_reg == 11'h000) begin
      rst_cnt_next = `CSW_BIDIR_RST_TCL;
    end else if (rst_cnt_reg != 11'h000) begin
      rst_cnt_next = rst_cnt_reg - 11'h001;
    end else begin
      rst_cnt_next = 11'h000;
    end
    drive_next = (rst_cnt_next != 11'h000);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= csw_pkg::CSW_ST_INIT;
      strap_reg     <= `CSW_STRAP_X4;
      xtal_prev_reg <= 1'b0;
      wd_cnt_reg    <= 4'h0;
      tr_cnt_reg    <= 5'h00;
      locked_reg    <= 1'b0;
      disc_reg      <= 1'b0;
      rst_cnt_reg   <= 11'h000;
      src_reg       <= csw_pkg::CSW_SRC_DIRECT;
      cfg_reg       <= `CSW_CFG_DIRECT;
      pll_en_reg    <= 1'b0;
      phase_reg     <= 1'b0;
      resync_reg    <= 1'b0;
      wd_irq_reg    <= 1'b0;
      ul_irq_reg    <= 1'b0;
      drive_reg     <= 1'b0;
      rlow_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      strap_reg     <= strap_next;
      xtal_prev_reg <= xtal_prev_next;
      wd_cnt_reg    <= wd_cnt_next;
      tr_cnt_reg    <= tr_cnt_next;
      locked_reg    <= locked_next;
      disc_reg      <= disc_next;
      rst_cnt_reg   <= rst_cnt_next;
      src_reg       <= src_next;
      cfg_reg       <= cfg_next;
      pll_en_reg    <= pll_en_next;
      phase_reg     <= phase_next;
      resync_reg    <= resync_next;
      wd_irq_reg    <= wd_irq_next;
      ul_irq_reg    <= ul_irq_next;
      drive_reg     <= drive_next;
      rlow_reg      <= rlow_next;
    end
  end

  // outputs straight from flops, except osc_amp_bypass (two cfg_reg bits) and reset_input_pin_o
  assign cpu_src            = src_reg;
  assign pll_cfg            = cfg_reg;
  assign pll_enable         = pll_en_reg;
  assign osc_amp_bypass     = cfg_reg.bypass & ~cfg_reg.out_prescale;
  assign ref_disconnect     = disc_reg;
  assign cpu_phase          = phase_reg;
  assign pll_resync         = resync_reg;
  assign osc_wd_irq         = wd_irq_reg;
  assign pll_unlock_irq     = ul_irq_reg;
  assign reset_input_pin_o  = 1'b0; // open drain: only ever pulls low
  assign reset_input_pin_oe = drive_reg;
  assign reset_pin_low      = rlow_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  direct_mode_a: assert property ((state_reg == csw_pkg::CSW_ST_EXT && strap_reg == `CSW_STRAP_DIRECT) |-> (osc_amp_bypass && cfg_reg.bypass && cpu_src == csw_pkg::CSW_SRC_DIRECT))
    else $error("direct drive setup wrong");
  phase_follow_a: assert property ((state_reg == csw_pkg::CSW_ST_EXT && strap_reg == `CSW_STRAP_DIRECT) ##1 (state_reg == csw_pkg::CSW_ST_EXT) |-> cpu_phase == $past(xtal_s))
    else $error("cpu phase does not follow input");
  pll_power_a: assert property ((state_reg == csw_pkg::CSW_ST_EXT && osc_watchdog_disable) |=> (!pll_enable || state_reg != csw_pkg::CSW_ST_EXT))
    else $error("pll left on with watchdog off");
  wd_clear_a: assert property ((state_reg == csw_pkg::CSW_ST_EXT && xtal_edge) |=> wd_cnt_reg == 4'h0)
    else $error("watchdog counter not cleared");
  wd_overflow_a: assert property ((state_reg == csw_pkg::CSW_ST_EXT && !osc_watchdog_disable && wd_cnt_reg == 4'hf && !xtal_edge) |=> (state_reg == csw_pkg::CSW_ST_FAIL && osc_wd_irq && cpu_src == csw_pkg::CSW_SRC_PLL_FREE))
    else $error("overflow did not switch");
  fail_sticky_a: assert property ((state_reg == csw_pkg::CSW_ST_FAIL) |=> (state_reg == csw_pkg::CSW_ST_FAIL && !osc_wd_irq && pll_enable))
    else $error("left failed state");
  disabled_ext_a: assert property ((state_reg == csw_pkg::CSW_ST_EXT && osc_watchdog_disable) |=> (cpu_src != csw_pkg::CSW_SRC_PLL_FREE))
    else $error("source not external");
  pll_no_wd_a: assert property ((state_reg == csw_pkg::CSW_ST_PLL) |-> (wd_cnt_reg == 4'h0 && !osc_wd_irq))
    else $error("watchdog active in pll mode");
  resync_gap_a: assert property ($rose(pll_resync) |-> tr_cnt_reg == 5'h00 && !ref_disconnect)
    else $error("resync at wrong count");
  cfg_hold_a: assert property ((state_reg != csw_pkg::CSW_ST_INIT) |-> pll_cfg == cfg_of(strap_reg))
    else $error("divider chain mismatch");
  unlock_a: assert property ((state_reg == csw_pkg::CSW_ST_PLL && locked_reg && !lock_s && !disc_reg) |=> (pll_unlock_irq && ref_disconnect) ##1 !pll_unlock_irq)
    else $error("unlock not handled");
  bidir_drive_a: assert property ((bidir_reset_req && rst_cnt_reg == 11'h000) |=> reset_input_pin_oe [*8])
    else $error("reset pin not driven");
  edge_sync_a: assert property (xtal_edge |-> xtal_s != $past(xtal_s))
    else $error("edge not from synchronised input");

  fail_seen_c:   cover property (state_reg == csw_pkg::CSW_ST_EXT ##1 state_reg == csw_pkg::CSW_ST_FAIL);
  unlock_seen_c: cover property (pll_unlock_irq);
  resync_seen_c: cover property (pll_resync);
  bidir_done_c:  cover property ($fell(reset_input_pin_oe));
endmodule

// [test/csw_osc_model.sv]
// external oscillator model that drives the crystal input pin
// assumes the bench gates it through run; a stopped crystal freezes at its last level
`timescale 1ns/10ps
module csw_osc_model #(
  parameter int HALF_NS  = 350,
  parameter int PHASE_NS = 20
) (
  input  wire logic run,
  output logic      xtal
);
  // a 350 ns half period gives a transition every 3.5 clk, far inside the watchdog span
  // start offset keeps every transition off both clk edges, so sampling never races
  // free toggling while running; a dead crystal simply stops toggling
  initial begin
    xtal = 1'b0;
    #(PHASE_NS);
    forever begin
      #(HALF_NS);
      if (run) begin
        xtal = ~xtal;
      end
    end
  end
endmodule

// [test/testbench.sv]
// self-checking bench for the cpu clock select and oscillator watchdog block
// assumes clk stands for the free pll clock and that straps are only taken at reset
`timescale 1ns/10ps
module testbench;
  logic                  clk;
  logic                  rstn;
  logic                  run;
  logic                  xtal;
  logic [2:0]            straps;
  logic                  wd_dis;
  logic                  lock;
  logic                  req;
  logic                  rst_pin;
  logic                  rst_pin_o;
  logic                  rst_pin_oe;
  csw_pkg::csw_src_t     cpu_src;
  csw_pkg::csw_pll_cfg_t pll_cfg;
  logic                  pll_enable;
  logic                  amp_bypass;
  logic                  ref_disc;
  logic                  cpu_phase;
  logic                  resync;
  logic                  wd_irq;
  logic                  unlock_irq;
  logic                  pin_low;
  int                    mismatches;
  int                    checks_done;
  int                    wd_irq_n;
  int                    unlock_n;
  int                    resync_n;

  // open-drain reset pin with pull-up: low only while the device drives it
  assign rst_pin = rst_pin_oe ? rst_pin_o : 1'b1;

  csw_osc_model u_csw_osc_model (.run(run), .xtal(xtal));

  csw_clock_select u_csw_clock_select (
    .clk(clk), .rstn(rstn), .crystal_input_pin(xtal), .clock_mode_straps(straps),
    .osc_watchdog_disable(wd_dis), .pll_lock(lock), .bidir_reset_req(req),
    .reset_input_pin_i(rst_pin), .reset_input_pin_o(rst_pin_o),
    .reset_input_pin_oe(rst_pin_oe), .cpu_src(cpu_src), .pll_cfg(pll_cfg),
    .pll_enable(pll_enable), .osc_amp_bypass(amp_bypass), .ref_disconnect(ref_disc),
    .cpu_phase(cpu_phase), .pll_resync(resync), .osc_wd_irq(wd_irq),
    .pll_unlock_irq(unlock_irq), .reset_pin_low(pin_low)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // pulse counters sample before the edge's updates land, so no race with the design
  always @(posedge clk) begin
    if (wd_irq === 1'b1) wd_irq_n++;
    if (unlock_irq === 1'b1) unlock_n++;
    if (resync === 1'b1) resync_n++;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // straps are only taken at reset, so every mode needs its own reset
  task automatic do_reset(input logic [2:0] strap, input logic dis);
    @(negedge clk);
    rstn = 1'b0;
    straps = strap;
    wd_dis = dis;
    lock = 1'b0;
    run = 1'b1;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    wd_irq_n = 0;
    unlock_n = 0;
    resync_n = 0;
  endtask

  // divider chain, source and power per strap, worked out from the mode table
  task automatic mode_check;
    logic [14:0] exp;
    for (int s = 0; s < 8; s++) begin
      case (s)
        7: exp = {3'h4, 7'h40, 3'h4, 2'h0};
        6: exp = {3'h4, 7'h30, 3'h4, 2'h0};
        5: exp = {3'h4, 7'h40, 3'h2, 2'h0};
        4: exp = {3'h4, 7'h28, 3'h2, 2'h0};
        3: exp = {3'h0, 7'h00, 3'h0, 2'h2};
        2: exp = {3'h2, 7'h28, 3'h2, 2'h0};
        1: exp = {3'h0, 7'h00, 3'h0, 2'h3};
        default: exp = {3'h2, 7'h40, 3'h2, 2'h0};
      endcase
      do_reset(3'(s), 1'b0);
      cmp(16'(pll_cfg), 16'(exp));
      cmp(16'(pll_enable), 16'h1);
      cmp(16'(amp_bypass), 16'(s == 3));
      cmp(16'(cpu_src), (s == 3) ? 16'h0 : (s == 1) ? 16'h1 : 16'h2);
    end
  endtask

  // phase toggles per input transition: every one in direct, every other in prescale
  task automatic phase_check(input logic [2:0] strap, input int div);
    int   ph_n;
    int   x_n;
    int   d;
    logic ph;
    logic x;
    do_reset(strap, 1'b0);
    ph_n = 0;
    x_n = 0;
    ph = cpu_phase;
    x = xtal;
    repeat (300) begin
      @(negedge clk);
      if (cpu_phase !== ph) ph_n++;
      if (xtal !== x) x_n++;
      ph = cpu_phase;
      x = xtal;
    end
    d = x_n / div - ph_n;
    cmp(16'(d >= -1 && d <= 1), 16'h1);
  endtask

  // crystal dies in direct drive: alarm after 16 quiet clocks, no way back but reset
  task automatic wd_fail_check;
    do_reset(3'h3, 1'b0);
    repeat (60) @(negedge clk);
    cmp(16'(wd_irq_n), 16'h0);
    run = 1'b0;
    repeat (13) @(negedge clk);
    cmp(16'(wd_irq_n), 16'h0);
    cmp(16'(cpu_src), 16'(csw_pkg::CSW_SRC_DIRECT));
    repeat (9) @(negedge clk);
    cmp(16'(wd_irq_n), 16'h1);
    cmp(16'(cpu_src), 16'(csw_pkg::CSW_SRC_PLL_FREE));
    run = 1'b1;
    repeat (60) @(negedge clk);
    cmp(16'(cpu_src), 16'(csw_pkg::CSW_SRC_PLL_FREE));
    cmp(16'(wd_irq_n), 16'h1);
  endtask

  // watchdog switched off: pll powered down and a dead crystal goes unnoticed
  task automatic wd_off_check(input logic [2:0] strap, input logic [15:0] src);
    do_reset(strap, 1'b1);
    cmp(16'(cpu_src), src);
    cmp(16'(pll_enable), 16'h0);
    run = 1'b0;
    repeat (40) @(negedge clk);
    cmp(16'(wd_irq_n), 16'h0);
    cmp(16'(cpu_src), src);
  endtask

  // multiply mode: resync cadence, no watchdog, unlock falls back to free pll
  task automatic pll_check;
    int   x_n;
    int   d;
    logic x;
    do_reset(3'h7, 1'b0);
    lock = 1'b1;
    repeat (4) @(negedge clk);
    resync_n = 0;
    x_n = 0;
    x = xtal;
    repeat (400) begin
      @(negedge clk);
      if (xtal !== x) x_n++;
      x = xtal;
    end
    d = x_n / 4 - resync_n;
    cmp(16'(d >= -1 && d <= 1), 16'h1);
    run = 1'b0;
    repeat (40) @(negedge clk);
    cmp(16'(wd_irq_n), 16'h0);
    cmp(16'(cpu_src), 16'(csw_pkg::CSW_SRC_PLL_MULT));
    lock = 1'b0;
    repeat (8) @(negedge clk);
    cmp(16'(unlock_n), 16'h1);
    cmp(16'(ref_disc), 16'h1);
    cmp(16'(cpu_src), 16'(csw_pkg::CSW_SRC_PLL_FREE));
  endtask

  // pin driven low for exactly 1024 clk cycles; a second request mid-drive is ignored
  task automatic bidir_check;
    int n;
    do_reset(3'h3, 1'b0);
    req = 1'b1;
    n = 0;
    // first sample sits in the cycle right after the request edge
    for (int i = 0; i < 1100; i++) begin
      @(negedge clk);
      req = (i == 100);
      if (rst_pin_oe === 1'b1) n++;
      if (i == 500) cmp(16'(pin_low), 16'h1);
    end
    cmp(16'(n), 16'd1024);
    cmp(16'(pin_low), 16'h0);
  endtask

  initial begin
    rstn = 1'b0;
    run = 1'b1;
    straps = 3'h3;
    wd_dis = 1'b0;
    lock = 1'b0;
    req = 1'b0;
    mismatches = 0;
    checks_done = 0;
    mode_check();
    phase_check(3'h3, 1);
    phase_check(3'h1, 2);
    wd_fail_check();
    wd_off_check(3'h3, 16'h0);
    wd_off_check(3'h1, 16'h1);
    pll_check();
    bidir_check();
    tally_and_finish();
  end

  // the run needs about 2700 clk; 10000 means something hung
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule
